/* verilog/pcu_pkg.sv */
// Constants and types for the program counter loader
package pcu_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W = 15;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 7;
  localparam int CALL_W = 11;
  localparam int BR_IMM_W = 9;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int BE_W = 4;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PC_LOW_BYTE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PC_HIGH_LATCH = 4'h4;

  // ----------------------------------------------------------------
  // Reset values and counter constants
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [HIGH_W-1:0] LATCH_RESET = 7'h00;
  localparam logic [LOW_W-1:0] RDATA_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
  localparam logic [PC_W-1:0] PC_MAX = 15'h7FFF;

  // Call keeps latch bits from this position upward
  localparam int CALL_LATCH_LSB = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_FETCH,
    OP_WRITE_LOW,
    OP_ADD_LOW,
    OP_CALL,
    OP_CALL_ACC,
    OP_BRANCH_ACC,
    OP_BRANCH_IMM
  } pcu_op_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } pcu_bus_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [HIGH_W-1:0] latch;
    pcu_bus_t bus;
    logic [LOW_W-1:0] rdata;
  } pcu_state_t;

endpackage : pcu_pkg

/* verilog/pcu_loader.sv */
// Program counter loader with Avalon-MM register access
`timescale 1ns/1ps

module pcu_loader (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // Instruction decoder command
  input wire logic op_valid_in,
  input wire pcu_pkg::pcu_op_t op_code_in,
  input wire logic [pcu_pkg::CALL_W-1:0] operand_in,
  input wire logic [pcu_pkg::LOW_W-1:0] write_data_in,
  input wire logic [pcu_pkg::LOW_W-1:0] accumulator_in,
  // Program memory fetch address
  output logic [pcu_pkg::PC_W-1:0] pc_out,
  // Avalon-MM slave
  input wire logic [pcu_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [pcu_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [pcu_pkg::BE_W-1:0] avs_byteenable_in,
  output logic [pcu_pkg::DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pcu_pkg::pcu_state_t st_r;
  pcu_pkg::pcu_state_t st_nxt;

  logic bus_req;
  logic bus_take;
  logic wr_low;
  logic wr_latch;
  logic [pcu_pkg::LOW_W-1:0] rd_val;
  logic [pcu_pkg::PC_W-1:0] pc_inc;
  logic [pcu_pkg::PC_W-1:0] acc_ext;
  logic [pcu_pkg::PC_W-1:0] imm_ext;
  logic [pcu_pkg::LOW_W-1:0] add_low;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------

  // Request present and the edge at which it completes
  assign bus_req = avs_read_in | avs_write_in;
  assign bus_take = bus_req & (st_r.bus == pcu_pkg::BUS_ACK) & ~op_valid_in;

  // Only the low byte lane carries register data
  assign wr_low = bus_take & avs_write_in & avs_byteenable_in[0] &
                  (avs_address_in == pcu_pkg::OFS_PC_LOW_BYTE);
  assign wr_latch = bus_take & avs_write_in & avs_byteenable_in[0] &
                    (avs_address_in == pcu_pkg::OFS_PC_HIGH_LATCH);

  // Readback mux; unmapped offsets read as zero
  always_comb begin
    unique case (avs_address_in)
      pcu_pkg::OFS_PC_LOW_BYTE: rd_val = st_r.pc[pcu_pkg::LOW_W-1:0];
      pcu_pkg::OFS_PC_HIGH_LATCH: rd_val = {1'b0, st_r.latch};
      default: rd_val = pcu_pkg::RDATA_RESET;
    endcase
  end

  // Stall on a request's first cycle and while the decoder owns the counter this cycle
  assign avs_waitrequest_out = bus_req &
                               ((st_r.bus == pcu_pkg::BUS_IDLE) | op_valid_in);
  assign avs_readdata_out = {{(pcu_pkg::DATA_W-pcu_pkg::LOW_W){1'b0}},
                             st_r.rdata};

  // ----------------------------------------------------------------
  // Target arithmetic
  // ----------------------------------------------------------------

  // Incremented counter, wraps modulo fifteen bits
  assign pc_inc = st_r.pc + pcu_pkg::PC_STEP;
  // Accumulator as unsigned offset
  assign acc_ext = {{pcu_pkg::HIGH_W{1'b0}}, accumulator_in};
  // Immediate as signed offset
  assign imm_ext = {{(pcu_pkg::PC_W-pcu_pkg::BR_IMM_W)
                     {operand_in[pcu_pkg::BR_IMM_W-1]}},
                    operand_in[pcu_pkg::BR_IMM_W-1:0]};
  // Low byte sum; carry is dropped, block crossing is software's care
  assign add_low = st_r.pc[pcu_pkg::LOW_W-1:0] + accumulator_in;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Bus handshake, data sampled every waiting cycle
    unique case (st_r.bus)
      pcu_pkg::BUS_IDLE: begin
        if (bus_req) begin
          st_nxt.bus = pcu_pkg::BUS_ACK;
          st_nxt.rdata = rd_val;
        end
      end
      pcu_pkg::BUS_ACK: begin
        st_nxt.rdata = rd_val;
        if (!op_valid_in) begin
          st_nxt.bus = pcu_pkg::BUS_IDLE;
        end
      end
    endcase
    // Counter loading from the decoder
    if (op_valid_in) begin
      unique case (op_code_in)
        pcu_pkg::OP_FETCH: begin
          st_nxt.pc = pc_inc;
        end
        pcu_pkg::OP_WRITE_LOW: begin
          st_nxt.pc = {st_r.latch, write_data_in};
        end
        pcu_pkg::OP_ADD_LOW: begin
          st_nxt.pc = {st_r.latch, add_low};
        end
        pcu_pkg::OP_CALL: begin
          st_nxt.pc = {st_r.latch[pcu_pkg::HIGH_W-1:pcu_pkg::CALL_LATCH_LSB],
                       operand_in};
        end
        pcu_pkg::OP_CALL_ACC: begin
          st_nxt.pc = {st_r.latch, accumulator_in};
        end
        pcu_pkg::OP_BRANCH_ACC: begin
          st_nxt.pc = pc_inc + acc_ext;
        end
        pcu_pkg::OP_BRANCH_IMM: begin
          st_nxt.pc = pc_inc + imm_ext;
        end
        default: begin
          st_nxt.pc = st_r.pc;
        end
      endcase
    end else if (wr_low) begin
      // Software write of low byte pulls high bits from latch
      st_nxt.pc = {st_r.latch,
                   avs_writedata_in[pcu_pkg::LOW_W-1:0]};
    end
    // Latch write never touches the counter itself
    if (wr_latch) begin
      st_nxt.latch = avs_writedata_in[pcu_pkg::HIGH_W-1:0];
    end
    // Any reset clears the counter
    if (reset_in) begin
      st_nxt.pc = pcu_pkg::PC_RESET;
      st_nxt.latch = pcu_pkg::LATCH_RESET;
      st_nxt.bus = pcu_pkg::BUS_IDLE;
      st_nxt.rdata = pcu_pkg::RDATA_RESET;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    st_r <= st_nxt;
  end

  // Fetch address straight from the counter flops
  assign pc_out = st_r.pc;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  // Width types used by the casts below
  typedef logic [pcu_pkg::PC_W-1:0] pcu_pc_t;
  typedef logic [pcu_pkg::LOW_W-1:0] pcu_low_t;

  // Decoder command of a given kind
  sequence s_op(pcu_pkg::pcu_op_t k);
    op_valid_in && op_code_in == k;
  endsequence

  // Bus write to the low byte completing
  sequence s_low_wr_taken;
    avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0] &&
    avs_address_in == pcu_pkg::OFS_PC_LOW_BYTE;
  endsequence

  // Bus read of the low byte completing
  sequence s_low_rd_taken;
    avs_read_in && !avs_waitrequest_out &&
    avs_address_in == pcu_pkg::OFS_PC_LOW_BYTE;
  endsequence

  // Bus write to the latch completing
  sequence s_latch_wr_taken;
    avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0] &&
    avs_address_in == pcu_pkg::OFS_PC_HIGH_LATCH;
  endsequence

  // Reset clears the counter and holds it clear
  property p_reset_clear;
    @(posedge core_clk_in)
    reset_in [*2] |=> pc_out == pcu_pkg::PC_RESET;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("counter not cleared by reset");

  // Counter wraps from all ones to zero
  property p_wrap;
    @(posedge core_clk_in) disable iff (reset_in)
    s_op(pcu_pkg::OP_FETCH) ##0 pc_out == pcu_pkg::PC_MAX
    |=> pc_out == pcu_pkg::PC_RESET;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap at fifteen bits");

  // Fetch advances by one
  property p_fetch;
    @(posedge core_clk_in) disable iff (reset_in)
    s_op(pcu_pkg::OP_FETCH)
    |=> pc_out == pcu_pc_t'($past(pc_out) + pcu_pkg::PC_STEP);
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch did not advance counter by one");

  // Decoder low byte write loads latch above
  property p_write_low;
    @(posedge core_clk_in) disable iff (reset_in)
    s_op(pcu_pkg::OP_WRITE_LOW)
    |=> pc_out == {$past(st_r.latch), $past(write_data_in)};
  endproperty
  a_write_low: assert property (p_write_low)
    else $error("low byte write did not load all fifteen bits");

  // Software low byte write loads latch above
  property p_bus_low;
    @(posedge core_clk_in) disable iff (reset_in)
    s_low_wr_taken
    |=> pc_out == {$past(st_r.latch),
                   $past(avs_writedata_in[pcu_pkg::LOW_W-1:0])};
  endproperty
  a_bus_low: assert property (p_bus_low)
    else $error("bus write of low byte not applied");

  // Read of low byte returns the counter a cycle earlier
  property p_bus_rd;
    @(posedge core_clk_in) disable iff (reset_in)
    s_low_rd_taken ##0 !$past(reset_in)
    |-> avs_readdata_out == {{(pcu_pkg::DATA_W-pcu_pkg::LOW_W){1'b0}},
                             $past(pc_out[pcu_pkg::LOW_W-1:0])};
  endproperty
  a_bus_rd: assert property (p_bus_rd)
    else $error("low byte readback wrong");

  // Latch write alone leaves the counter untouched
  property p_latch_hidden;
    @(posedge core_clk_in) disable iff (reset_in)
    s_latch_wr_taken ##0 !op_valid_in |=> $stable(pc_out);
  endproperty
  a_latch_hidden: assert property (p_latch_hidden)
    else $error("latch write reached the counter");

  // Computed jump from low byte sum
  property p_add;
    @(posedge core_clk_in) disable iff (reset_in)
    s_op(pcu_pkg::OP_ADD_LOW)
    |=> pc_out == {$past(st_r.latch),
                   pcu_low_t'($past(pc_out[pcu_pkg::LOW_W-1:0]) +
                          $past(accumulator_in))};
  endproperty
  a_add: assert property (p_add)
    else $error("computed jump target wrong");

  // Absolute call mixes latch and operand
  property p_call;
    @(posedge core_clk_in) disable iff (reset_in)
    s_op(pcu_pkg::OP_CALL)
    |=> pc_out[pcu_pkg::CALL_W-1:0] == $past(operand_in) &&
        pc_out[pcu_pkg::PC_W-1:pcu_pkg::CALL_W] ==
        $past(st_r.latch[pcu_pkg::HIGH_W-1:pcu_pkg::CALL_LATCH_LSB]);
  endproperty
  a_call: assert property (p_call)
    else $error("absolute call target wrong");

  // Call through accumulator
  property p_call_acc;
    @(posedge core_clk_in) disable iff (reset_in)
    s_op(pcu_pkg::OP_CALL_ACC)
    |=> pc_out == {$past(st_r.latch), $past(accumulator_in)};
  endproperty
  a_call_acc: assert property (p_call_acc)
    else $error("accumulator call target wrong");

  // Accumulator branch, unsigned, full width
  property p_br_acc;
    @(posedge core_clk_in) disable iff (reset_in)
    s_op(pcu_pkg::OP_BRANCH_ACC)
    |=> pc_out == pcu_pc_t'($past(pc_out) + pcu_pkg::PC_STEP +
                            pcu_pc_t'($past(accumulator_in)));
  endproperty
  a_br_acc: assert property (p_br_acc)
    else $error("accumulator branch target wrong");

  // Immediate branch, signed, full width
  property p_br_imm;
    @(posedge core_clk_in) disable iff (reset_in)
    s_op(pcu_pkg::OP_BRANCH_IMM)
    |=> pc_out == pcu_pc_t'($past(pc_out) + pcu_pkg::PC_STEP +
                            pcu_pc_t'(signed'(
                            $past(operand_in[pcu_pkg::BR_IMM_W-1:0]))));
  endproperty
  a_br_imm: assert property (p_br_imm)
    else $error("immediate branch target wrong");

  // Idle request is answered on the next cycle unless stalled
  property p_bus_answer;
    @(posedge core_clk_in) disable iff (reset_in)
    bus_req && st_r.bus == pcu_pkg::BUS_IDLE ##1 !op_valid_in
    |-> !avs_waitrequest_out;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus request not answered");

  // Decoder command holds off any bus completion in its cycle
  property p_bus_stall;
    @(posedge core_clk_in) disable iff (reset_in)
    bus_req && op_valid_in |-> avs_waitrequest_out;
  endproperty
  a_bus_stall: assert property (p_bus_stall)
    else $error("bus completed beside a decoder command");

  // Latch write lands in the latch field
  property p_latch_wr;
    @(posedge core_clk_in) disable iff (reset_in)
    s_latch_wr_taken
    |=> st_r.latch == $past(avs_writedata_in[pcu_pkg::HIGH_W-1:0]);
  endproperty
  a_latch_wr: assert property (p_latch_wr)
    else $error("latch write not stored");

endmodule : pcu_loader

/* dv/pcu_decoder_model.sv */
// Behavioural model of the instruction decoder feeding the loader
`timescale 1ns/1ps

module pcu_decoder_model (
  // Clock
  input wire logic core_clk_in,
  // Command to the loader
  output logic op_valid_out,
  output pcu_pkg::pcu_op_t op_code_out,
  output logic [pcu_pkg::CALL_W-1:0] operand_out,
  output logic [pcu_pkg::LOW_W-1:0] write_data_out,
  output logic [pcu_pkg::LOW_W-1:0] accumulator_out
);
  // Quiet at time zero
  initial begin
    op_valid_out = 1'b0;
    op_code_out = pcu_pkg::OP_FETCH;
    operand_out = 11'h000;
    write_data_out = 8'h00;
    accumulator_out = 8'h00;
  end

  // One command per cycle; valid stays up for back-to-back use
  task automatic send(input pcu_pkg::pcu_op_t op, input logic [10:0] opr,
                      input logic [7:0] wd, input logic [7:0] acc);
    @(posedge core_clk_in);
    op_valid_out <= 1'b1;
    op_code_out <= op;
    operand_out <= opr;
    write_data_out <= wd;
    accumulator_out <= acc;
  endtask : send

  // Drop valid; stale operand and data fields are scrambled so nothing relies on them
  task automatic idle();
    @(posedge core_clk_in);
    op_valid_out <= 1'b0;
    operand_out <= ~operand_out;
    write_data_out <= ~write_data_out;
    accumulator_out <= ~accumulator_out;
  endtask : idle
endmodule : pcu_decoder_model

/* dv/testbench.sv */
// Self-checking bench for the program counter loader
`timescale 1ns/1ps

module testbench;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic op_valid;
  pcu_pkg::pcu_op_t op_code;
  logic [10:0] operand;
  logic [7:0] wdat, accv;
  logic [14:0] pc_out;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [14:0] exp_pc = 15'h0000, exp_pc_q[$];
  logic [6:0] latch_m = 7'h00;
  logic [31:0] exp_rd_q[$];
  logic pend = 1'b0;
  int mismatches = 0, cmp_count = 0;

  // Clock, 100 ns period
  always #50 core_clk_in = ~core_clk_in;

  pcu_decoder_model i_pcu_decoder_model (.core_clk_in(core_clk_in),
    .op_valid_out(op_valid), .op_code_out(op_code), .operand_out(operand),
    .write_data_out(wdat), .accumulator_out(accv));

  pcu_loader i_pcu_loader (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .op_valid_in(op_valid), .op_code_in(op_code), .operand_in(operand),
    .write_data_in(wdat), .accumulator_in(accv), .pc_out(pc_out),
    .avs_address_in(avs_address), .avs_read_in(avs_read),
    .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_byteenable_in(avs_byteenable), .avs_readdata_out(avs_readdata),
    .avs_waitrequest_out(avs_waitrequest));

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic check_pc();
    logic [14:0] e;
    e = exp_pc_q.pop_front();
    cmp_count++;
    if (pc_out !== e) begin
      mismatches++;
      $display("[FAIL] %0t pc got %h exp %h", $time, pc_out, e);
    end
  endtask : check_pc

  task automatic check_rd();
    logic [31:0] e;
    e = exp_rd_q.pop_front();
    cmp_count++;
    if (avs_readdata !== e) begin
      mismatches++;
      $display("[FAIL] %0t read got %h exp %h", $time, avs_readdata, e);
    end
  endtask : check_rd

  // Monitor: pc after each taken command or low byte write, read data
  always @(posedge core_clk_in) begin
    if (pend) check_pc();
    if (avs_read && avs_waitrequest === 1'b0) check_rd();
    pend = !reset_in && (op_valid === 1'b1 || (avs_write &&
           avs_waitrequest === 1'b0 && avs_address == 4'h0 &&
           avs_byteenable[0]));
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task automatic bus_xfer(input logic wr, input logic [3:0] a,
                          input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk_in);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge core_clk_in);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      n++;
      @(posedge core_clk_in);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d;
    if (n >= 100) begin
      mismatches++;
      $display("[FAIL] %0t bus answer missing", $time);
      end_of_test();
    end
  endtask : bus_xfer

  task automatic bus_write(input logic [3:0] a, input logic [31:0] d,
                           input logic [3:0] be);
    if (a == 4'h0 && be[0]) begin
      exp_pc = {latch_m, d[7:0]};
      exp_pc_q.push_back(exp_pc);
    end
    if (a == 4'h4 && be[0]) latch_m = d[6:0];
    bus_xfer(1'b1, a, d, be);
  endtask : bus_write

  task automatic bus_read(input logic [3:0] a, input logic [31:0] e);
    exp_rd_q.push_back(e);
    bus_xfer(1'b0, a, $urandom, 4'hF);
  endtask : bus_read

  task automatic cmd(input pcu_pkg::pcu_op_t op, input logic [10:0] o,
                     input logic [7:0] wd, input logic [7:0] a);
    case (op)
      pcu_pkg::OP_FETCH: exp_pc = exp_pc + 15'h0001;
      pcu_pkg::OP_WRITE_LOW: exp_pc = {latch_m, wd};
      pcu_pkg::OP_ADD_LOW: exp_pc = {latch_m, 8'(exp_pc[7:0] + a)};
      pcu_pkg::OP_CALL: exp_pc = {latch_m[6:3], o};
      pcu_pkg::OP_CALL_ACC: exp_pc = {latch_m, a};
      pcu_pkg::OP_BRANCH_ACC: exp_pc = exp_pc + 15'h0001 + {7'h00, a};
      default: exp_pc = exp_pc + 15'h0001 + {{6{o[8]}}, o[8:0]};
    endcase
    exp_pc_q.push_back(exp_pc);
    i_pcu_decoder_model.send(op, o, wd, a);
  endtask : cmd

  task automatic end_of_test();
    if (exp_pc_q.size() != 0 || exp_rd_q.size() != 0) mismatches++;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge core_clk_in);
    mismatches++;
    end_of_test();
  end

  // Main sequence
  initial begin
    int k;
    void'($urandom(32'h3240));
    repeat (4) @(posedge core_clk_in);
    reset_in <= 1'b0;
    bus_read(4'h0, 32'h0);
    bus_read(4'h4, 32'h0);
    bus_read(4'h8, 32'h0);
    repeat (3) cmd(pcu_pkg::OP_FETCH, 11'h0, 8'h0, 8'h0);
    i_pcu_decoder_model.idle();
    bus_write(4'h4, 32'h7F, 4'h1);
    bus_write(4'h0, 32'hFF, 4'h1);
    cmd(pcu_pkg::OP_FETCH, 11'h0, 8'h0, 8'h0);
    i_pcu_decoder_model.idle();
    bus_write(4'h0, 32'h55, 4'hE);
    bus_write(4'h8, 32'h66, 4'hF);
    bus_read(4'h0, {24'h0, exp_pc[7:0]});
    bus_write(4'h4, 32'h12, 4'hF);
    bus_read(4'h4, 32'h12);
    bus_write(4'h0, 32'hF0, 4'h1);
    cmd(pcu_pkg::OP_ADD_LOW, 11'h0, 8'h0, 8'h20);
    cmd(pcu_pkg::OP_CALL, 11'h7AB, 8'h0, 8'h0);
    cmd(pcu_pkg::OP_CALL_ACC, 11'h0, 8'h0, 8'h3C);
    cmd(pcu_pkg::OP_BRANCH_ACC, 11'h0, 8'h0, 8'hFF);
    cmd(pcu_pkg::OP_BRANCH_IMM, 11'h100, 8'h0, 8'h0);
    cmd(pcu_pkg::OP_WRITE_LOW, 11'h0, 8'hA5, 8'h0);
    for (int i = 0; i < 60; i++) begin
      k = $urandom_range(7);
      if (k == 7) begin
        i_pcu_decoder_model.idle();
        bus_write(4'h4, $urandom, 4'hF);
        bus_read(4'h0, {24'h0, exp_pc[7:0]});
      end else begin
        cmd(pcu_pkg::pcu_op_t'(k), 11'($urandom), 8'($urandom),
            8'($urandom));
      end
    end
    i_pcu_decoder_model.idle();
    // Bus request stalled behind decoder commands
    fork
      bus_write(4'h4, 32'h5A, 4'h1);
      begin
        repeat (2) cmd(pcu_pkg::OP_FETCH, 11'h0, 8'h0, 8'h0);
        i_pcu_decoder_model.idle();
      end
    join
    bus_read(4'h4, 32'h5A);
    // Second reset in mid-run
    @(posedge core_clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    exp_pc = 15'h0000;
    latch_m = 7'h00;
    bus_read(4'h0, 32'h0);
    bus_read(4'h4, 32'h0);
    cmd(pcu_pkg::OP_FETCH, 11'h0, 8'h0, 8'h0);
    i_pcu_decoder_model.idle();
    repeat (2) @(posedge core_clk_in);
    end_of_test();
  end
endmodule : testbench
